// *** verilog/charger_control_registers.sv ***
// charger control register bank with write protection and charger gating
// assumes a bus master that never overlaps strobes; charger FSM lives outside
//
// The address-and-strobe port was chosen for this implementation.
module charger_control_registers (
  input  wire logic        clk,                      // 25 MHz clock
  input  wire logic        reset_n,                  // async reset, active low
  input  wire logic [7:0]  addr,                     // register address
  input  wire logic [7:0]  wdata,                    // write data
  input  wire logic        wr,                       // write strobe
  input  wire logic        rd,                       // read strobe
  output logic      [7:0]  rdata,                    // read data, cycle after rd
  input  wire logic        application_write_protect,// 1 = protected
  input  wire logic        warm_cool_threshold_select,// threshold pair status
  input  wire logic        zone_charger_off,         // zone asks charger off
  input  wire logic        hot_zone_voltage_scaling, // hot zone scaling setting
  input  wire logic        cold_zone_voltage_scaling,// cold zone scaling setting
  input  wire logic        in_maintain,              // charger in maintain state
  input  wire logic        in_maintain_done,         // charger in maintain-done
  input  wire logic        battery_below_recharge,   // vbat below recharge level
  output logic             thermal_zone_control_enable, // zone enable
  output logic             charger_on,               // charger allowed to run
  output logic             allow_maintain_done,      // maintain to done allowed
  output logic             restart_charge,           // restart request
  output logic             hot_scaling_active,       // effective hot scaling
  output logic             cold_scaling_active,      // effective cold scaling
  output charger_regs_pkg::settings_type settings    // level selections
);

  // ************************************************
  // state
  // ************************************************
  typedef struct packed {
    logic [7:0] rdata;
    logic       zone_enable;
    logic [7:0] primary;
    logic [7:0] precharge;
    logic [7:0] timer;
    logic       charger_on;
    logic       allow_done;
    logic       restart;
    charger_regs_pkg::settings_type settings;
  } state_type;

  state_type state;
  state_type next_state;
  logic      writable;

  always_comb begin
    next_state = state;
    writable = !application_write_protect;
    next_state.rdata = 8'h00;
    if (rd) begin
      unique case (addr)
        charger_regs_pkg::thermal_zone_config_addr: begin
          next_state.rdata[charger_regs_pkg::zone_enable_bit] = state.zone_enable;
          next_state.rdata[charger_regs_pkg::warm_cool_bit] = warm_cool_threshold_select; // R2
        end
        charger_regs_pkg::charge_control_primary_addr: next_state.rdata = state.primary;
        charger_regs_pkg::precharge_and_termination_addr: next_state.rdata = state.precharge;
        charger_regs_pkg::charge_timer_config_addr: next_state.rdata = state.timer;
        default: next_state.rdata = 8'h00;
      endcase
    end
    if (wr) begin
      unique case (addr)
        charger_regs_pkg::thermal_zone_config_addr: begin
          // warm/cool bit is status only, write ignored
          next_state.zone_enable = wdata[charger_regs_pkg::zone_enable_bit]; // R2
        end
        charger_regs_pkg::charge_control_primary_addr: begin
          if (writable) begin
            next_state.primary = wdata & charger_regs_pkg::primary_mask; // R3
          end
        end
        charger_regs_pkg::precharge_and_termination_addr: begin
          if (writable) begin
            next_state.precharge = wdata & charger_regs_pkg::precharge_mask; // R3
          end
        end
        charger_regs_pkg::charge_timer_config_addr: begin
          if (writable) begin
            next_state.timer = wdata & charger_regs_pkg::timer_mask; // R3
          end
        end
        default: begin
        end
      endcase
    end
    // field decode from current register contents
    next_state.settings.auto_stop = state.primary[7];
    next_state.settings.recharge_offset = state.primary[6:5]; // R6
    next_state.settings.battery_regulation_level = state.primary[2:1]; // R6
    next_state.settings.charge_enable = state.primary[0];
    next_state.settings.precharge_voltage_level = state.precharge[6:4]; // R6
    next_state.settings.precharge_current_level = state.precharge[3:2]; // R6
    next_state.settings.termination_current_level = state.precharge[1:0]; // R6
    next_state.settings.auto_restart = state.timer[6];
    next_state.settings.maintain_timer = state.timer[5:4]; // R6
    next_state.settings.fast_charge_timer = state.timer[3:2]; // R6
    next_state.settings.precharge_timer = state.timer[1:0]; // R6
    // zone status only counts when zone control is on
    next_state.charger_on = state.primary[charger_regs_pkg::charge_enable_bit]
                            & !(state.zone_enable & zone_charger_off); // R1 R7
    next_state.allow_done = in_maintain
                            & state.primary[charger_regs_pkg::auto_stop_bit]; // R4
    next_state.restart = in_maintain_done & battery_below_recharge
                         & state.timer[charger_regs_pkg::auto_restart_bit]; // R5
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= '0;
      state.primary <= charger_regs_pkg::primary_reset;
      state.precharge <= charger_regs_pkg::precharge_reset;
      state.timer <= charger_regs_pkg::timer_reset;
    end else begin
      state <= next_state;
    end
  end

  // ************************************************
  // zone scaling gates
  // ************************************************
  zone_gate hot_gate (
    .clk       (clk),
    .reset_n   (reset_n),
    .enable    (state.zone_enable),
    .setting   (hot_zone_voltage_scaling),
    .effective (hot_scaling_active)
  );

  zone_gate cold_gate (
    .clk       (clk),
    .reset_n   (reset_n),
    .enable    (state.zone_enable),
    .setting   (cold_zone_voltage_scaling),
    .effective (cold_scaling_active)
  );

  assign rdata = state.rdata;
  assign thermal_zone_control_enable = state.zone_enable;
  assign charger_on = state.charger_on;
  assign allow_maintain_done = state.allow_done;
  assign restart_charge = state.restart;
  assign settings = state.settings;

  // ************************************************
  // checks
  // ************************************************
  chk_protect_blocks_write: assert property (@(posedge clk) disable iff (!reset_n) // R3
    (wr && application_write_protect && addr == charger_regs_pkg::charge_timer_config_addr)
    |=> $stable(state.timer)) else $error("protected write changed timer register");

  chk_write_lands: assert property (@(posedge clk) disable iff (!reset_n) // R3
    (wr && !application_write_protect && addr == charger_regs_pkg::precharge_and_termination_addr)
    |=> state.precharge == ($past(wdata) & charger_regs_pkg::precharge_mask))
    else $error("unprotected write not stored");

  chk_warm_cool_read: assert property (@(posedge clk) disable iff (!reset_n) // R2
    (rd && addr == charger_regs_pkg::thermal_zone_config_addr)
    |=> rdata[0] == $past(warm_cool_threshold_select)) else $error("warm/cool readback wrong");

  chk_zone_off: assert property (@(posedge clk) disable iff (!reset_n) // R1
    (state.zone_enable && zone_charger_off) |=> !charger_on) else $error("zone off ignored");

  chk_zone_ignored: assert property (@(posedge clk) disable iff (!reset_n) // R1
    (!state.zone_enable && state.primary[0]) |=> charger_on) else $error("zone acted while off");

  chk_auto_stop: assert property (@(posedge clk) disable iff (!reset_n) // R4
    allow_maintain_done |-> $past(state.primary[7]) && $past(in_maintain))
    else $error("maintain-done allowed without auto-stop");

  chk_auto_restart: assert property (@(posedge clk) disable iff (!reset_n) // R5
    (in_maintain_done && battery_below_recharge && state.timer[6]) |=> restart_charge)
    else $error("restart missed");

  chk_scaling_gate: assert property (@(posedge clk) disable iff (!reset_n) // R7
    hot_scaling_active |-> $past(state.zone_enable)) else $error("scaling without enable");

  chk_level_decode: assert property (@(posedge clk) disable iff (!reset_n) // R6
    ##1 settings.fast_charge_timer == $past(state.timer[3:2]))
    else $error("timer field decode wrong");

  // ************************************************
  // protection, readback and gating checks
  // ************************************************
  // each protected register gets its own check, so one bad decode cannot hide
  chk_protect_primary: assert property (@(posedge clk) disable iff (!reset_n) // R3
    (wr && application_write_protect && addr == charger_regs_pkg::charge_control_primary_addr)
    |=> $stable(state.primary)) else $error("protected write changed primary register");

  chk_protect_precharge: assert property (@(posedge clk) disable iff (!reset_n) // R3
    (wr && application_write_protect
     && addr == charger_regs_pkg::precharge_and_termination_addr)
    |=> $stable(state.precharge)) else $error("protected write changed precharge register");

  // zone enable stays writable even while the charger registers are locked
  chk_zone_unprotected: assert property (@(posedge clk) disable iff (!reset_n) // R3
    (wr && addr == charger_regs_pkg::thermal_zone_config_addr)
    |=> state.zone_enable == $past(wdata[charger_regs_pkg::zone_enable_bit]))
    else $error("zone enable write lost");

  chk_read_primary: assert property (@(posedge clk) disable iff (!reset_n) // R3
    (rd && addr == charger_regs_pkg::charge_control_primary_addr)
    |=> rdata == $past(state.primary)) else $error("primary readback wrong");

  chk_stop_gate: assert property (@(posedge clk) disable iff (!reset_n) // R4
    !state.primary[charger_regs_pkg::auto_stop_bit] |=> !allow_maintain_done)
    else $error("maintain-done allowed with auto-stop off");

  chk_stop_pass: assert property (@(posedge clk) disable iff (!reset_n) // R4
    (in_maintain && state.primary[charger_regs_pkg::auto_stop_bit]) |=> allow_maintain_done)
    else $error("maintain-done blocked with auto-stop on");

  chk_restart_gate: assert property (@(posedge clk) disable iff (!reset_n) // R5
    !state.timer[charger_regs_pkg::auto_restart_bit] |=> !restart_charge)
    else $error("restart with auto-restart off");

  chk_cold_gate: assert property (@(posedge clk) disable iff (!reset_n) // R7
    cold_scaling_active |-> $past(state.zone_enable)) else $error("cold scaling without enable");

  chk_scaling_pass: assert property (@(posedge clk) disable iff (!reset_n) // R7
    (state.zone_enable && hot_zone_voltage_scaling) |=> hot_scaling_active)
    else $error("hot scaling dropped while enabled");

  chk_zone_block: assert property (@(posedge clk) disable iff (!reset_n) // R7
    !state.zone_enable |=> !hot_scaling_active && !cold_scaling_active)
    else $error("zone scaling acted while disabled");

endmodule : charger_control_registers

// *** verilog/charger_regs_pkg.sv ***
// package for the charger control register bank
// assumes a simple single-cycle register port and one 25 MHz clock
// Behaviour
// (R1) zone control enable lets temperature zone act
// (R2) warm/cool select bit is read-only status
// (R3) three control registers ignore writes when protected
// (R4) auto-stop gates maintain to maintain-done move
// (R5) auto-restart restarts charge below recharge threshold
// (R6) setting fields select one level each
// (R7) zone on/off and scaling need zone enable
package charger_regs_pkg;

  // ************************************************
  // register map
  // ************************************************
  localparam logic [7:0] thermal_zone_config_addr       = 8'h1C;
  localparam logic [7:0] charge_control_primary_addr    = 8'h1D;
  localparam logic [7:0] precharge_and_termination_addr = 8'h1E;
  localparam logic [7:0] charge_timer_config_addr       = 8'h1F;

  // ************************************************
  // field positions and reset values
  // ************************************************
  localparam int zone_enable_bit   = 1;
  localparam int warm_cool_bit     = 0;
  localparam int auto_stop_bit     = 7;
  localparam int charge_enable_bit = 0;
  localparam int auto_restart_bit  = 6;
  localparam logic [7:0] primary_reset = 8'h00;
  localparam logic [7:0] precharge_reset = 8'h00;
  localparam logic [7:0] timer_reset = 8'h00;
  localparam logic [7:0] primary_mask = 8'hF7;
  localparam logic [7:0] precharge_mask = 8'h7F;
  localparam logic [7:0] timer_mask = 8'h7F;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_type;

  typedef struct packed {
    logic       auto_stop;
    logic [1:0] recharge_offset;
    logic [1:0] battery_regulation_level;
    logic       charge_enable;
    logic [2:0] precharge_voltage_level;
    logic [1:0] precharge_current_level;
    logic [1:0] termination_current_level;
    logic       auto_restart;
    logic [1:0] maintain_timer;
    logic [1:0] fast_charge_timer;
    logic [1:0] precharge_timer;
  } settings_type;

endpackage : charger_regs_pkg

// *** verilog/zone_gate.sv ***
// gates one zone setting by the zone control enable
// assumes settings are synchronous to clk
module zone_gate (
  input  wire logic clk,      // clock
  input  wire logic reset_n,  // async reset, active low
  input  wire logic enable,   // zone control enable
  input  wire logic setting,  // raw zone setting
  output logic      effective // gated, registered
);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      effective <= 1'b0;
    end else begin
      effective <= enable & setting; // R7
    end
  end
endmodule : zone_gate

// *** test/tb_top.sv ***
// self-checking bench for the charger control register bank
// assumes the single-cycle register port and a one-cycle lag on derived outputs
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic       clk, reset_n, wr, rd, protect, wcs, zone_off, hot_set, cold_set;
  logic       in_mt, in_mtd, below, zone_en, chg_on, allow_done, restart, hot_act, cold_act;
  logic [7:0] addr, wdata, rdata, pat;
  logic [7:0] shadow [0:3];
  charger_regs_pkg::settings_type settings;
  int         errors, checked;

  charger_control_registers charger_control_registers_inst (
    .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .application_write_protect(protect), .warm_cool_threshold_select(wcs),
    .zone_charger_off(zone_off), .hot_zone_voltage_scaling(hot_set),
    .cold_zone_voltage_scaling(cold_set), .in_maintain(in_mt), .in_maintain_done(in_mtd),
    .battery_below_recharge(below), .thermal_zone_control_enable(zone_en),
    .charger_on(chg_on), .allow_maintain_done(allow_done), .restart_charge(restart),
    .hot_scaling_active(hot_act), .cold_scaling_active(cold_act), .settings(settings));

  always #20 clk = ~clk;

  // ************************************************
  // tasks
  // ************************************************
  task test_done;
    if (errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done

  task cmp_val(input logic [19:0] got, input logic [19:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_val

  // shadow keeps what software should see; only 0x1C bit1 survives protection
  task reg_write(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] m [0:3];
    m = '{8'h02, charger_regs_pkg::primary_mask, charger_regs_pkg::precharge_mask,
          charger_regs_pkg::timer_mask};
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    if (a[7:2] == 6'h07 && (a[1:0] == 2'h0 || !protect)) shadow[a[1:0]] = d & m[a[1:0]];
  endtask : reg_write

  task check_reg(input logic [7:0] a);
    logic [7:0] exp;
    exp = 8'h00;
    if (a[7:2] == 6'h07) exp = a[1:0] == 2'h0 ? {6'h00, shadow[0][1], wcs} : shadow[a[1:0]];
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    cmp_val({12'h000, rdata}, {12'h000, exp});
  endtask : check_reg

  task check_outputs;
    logic en;
    repeat (3) @(posedge clk);
    @(negedge clk);
    en = shadow[0][1];
    cmp_val(20'(zone_en), 20'(en));
    cmp_val(20'(chg_on), 20'(shadow[1][0] & !(en & zone_off)));
    cmp_val(20'(allow_done), 20'(in_mt & shadow[1][7]));
    cmp_val(20'(restart), 20'(in_mtd & below & shadow[3][6]));
    cmp_val(20'({hot_act, cold_act}), 20'({hot_set & en, cold_set & en}));
    cmp_val(settings, {shadow[1][7:5], shadow[1][2:0], shadow[2][6:0], shadow[3][6:0]});
  endtask : check_outputs

  // ************************************************
  // sequence
  // ************************************************
  initial begin
    clk = 1'b0; reset_n = 1'b0; addr = 8'h00; wdata = 8'h00; wr = 1'b0; rd = 1'b0;
    {protect, wcs, zone_off, hot_set, cold_set, in_mt, in_mtd, below} = 8'h00;
    shadow = '{8'h00, 8'h00, 8'h00, 8'h00};
    errors = 0;
    checked = 0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 5; i++) check_reg(8'(8'h1C + i));
    check_outputs;
    for (int i = 0; i < 4; i++) begin
      pat = 8'(i * 8'h55);
      for (int a = 1; a < 4; a++) reg_write(8'(8'h1C + a), pat);
      for (int a = 1; a < 4; a++) check_reg(8'(8'h1C + a));
      check_outputs;
    end
    @(posedge clk) {protect, wcs} <= 2'h3;
    for (int a = 1; a < 4; a++) reg_write(8'(8'h1C + a), 8'h00);
    for (int a = 1; a < 4; a++) check_reg(8'(8'h1C + a));
    reg_write(8'h1C, 8'h00);
    check_reg(8'h1C);
    reg_write(8'h1C, 8'h03);
    check_reg(8'h1C);
    @(posedge clk) protect <= 1'b0;
    reg_write(8'h1D, 8'h0A);
    check_reg(8'h1D);
    // every input mix against both zone enables and both auto bit values
    for (int e = 0; e < 2; e++) begin
      reg_write(8'h1C, e ? 8'h02 : 8'h00);
      for (int r = 0; r < 2; r++) begin
        reg_write(8'h1D, r ? 8'hFF : 8'h00);
        reg_write(8'h1F, r ? 8'hFF : 8'h00);
        for (int k = 0; k < 64; k++) begin
          @(posedge clk) {zone_off, hot_set, cold_set, in_mt, in_mtd, below} <= 6'(k);
          check_outputs;
        end
      end
    end
    test_done;
  end

  // the sequence needs about 1200 cycles
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    test_done;
  end
endmodule : tb_top
